/* src/pdmcu_pkg.sv */
// constants and carrier types of the device memory command unit
// Summary of operation
// - bit units: one nibble per point, first high
// - word units of bits: sixteen points, low byte first
// - word devices: one 16-bit value, low first
// - non-integer word content returned raw
// - 00h reads bits, at most 256 points
// - 01h reads 32 bit-words or 64 words
// - 02h writes bits, at most 160 points
// - 03h writes 10 bit-words or 64 words
// - 04h sets/resets listed bits, 80 points
// - 05h random word write, 10, no C200-C255
// - 13h requests run, 14h requests stop
// - 15h returns the model name code
// - 16h echoes up to 254 bytes
// - multi-byte values travel low byte first
// - binary data code only; ascii setting answered 52h
`default_nettype none
package pdmcu_pkg;
   // command codes
   localparam logic [7:0] CMD_RD_BIT  = 8'h00;
   localparam logic [7:0] CMD_RD_WORD = 8'h01;
   localparam logic [7:0] CMD_WR_BIT  = 8'h02;
   localparam logic [7:0] CMD_WR_WORD = 8'h03;
   localparam logic [7:0] CMD_TST_BIT = 8'h04;
   localparam logic [7:0] CMD_TST_WRD = 8'h05;
   localparam logic [7:0] CMD_RUN     = 8'h13;
   localparam logic [7:0] CMD_STOP    = 8'h14;
   localparam logic [7:0] CMD_MODEL   = 8'h15;
   localparam logic [7:0] CMD_LOOP    = 8'h16;
   // point limits per transfer
   localparam logic [15:0] LIM_RD_BIT  = 16'h0100;
   localparam logic [15:0] LIM_RD_BWRD = 16'h0020;
   localparam logic [15:0] LIM_WORD    = 16'h0040;
   localparam logic [15:0] LIM_WR_BIT  = 16'h00a0;
   localparam logic [15:0] LIM_WR_BWRD = 16'h000a;
   localparam logic [15:0] LIM_TST_BIT = 16'h0050;
   localparam logic [15:0] LIM_TST_WRD = 16'h000a;
   localparam logic [15:0] LIM_LOOP    = 16'h00fe;
   localparam logic [15:0] LIM_HI_CNT  = 16'h0020;
   // device code byte: bit 7 marks a word device
   localparam int          DEV_WORD_BIT = 7;
   localparam logic [7:0]  DEV_CNT_CUR  = 8'h83;
   localparam logic [15:0] CNT_HI_FIRST = 16'h00c8;
   // answer status bytes
   localparam logic [7:0] STS_OK   = 8'h00;
   localparam logic [7:0] STS_CMD  = 8'h50;
   localparam logic [7:0] STS_CNT  = 8'h51;
   localparam logic [7:0] STS_MODE = 8'h52;
   localparam logic [7:0] STS_DEV  = 8'h53;
   // header byte counts
   localparam logic [2:0] HDR_BATCH = 3'd5;
   localparam logic [2:0] HDR_COUNT = 3'd1;
   localparam logic [2:0] HDR_NONE  = 3'd0;
   // one access to controller device memory
   typedef struct packed {
      logic        we;     // write when set
      logic        wmode;  // sixteen points / one word when set
      logic [7:0]  code;   // device code
      logic [15:0] num;    // device number
      logic [15:0] wdata;  // bit in wdata[0] when wmode clear
   } pdmcu_mem_req_s;
   // one byte on the response stream
   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } pdmcu_byte_s;
endpackage
`default_nettype wire

/* src/pdmcu_top.sv */
// binary device memory command interpreter
`default_nettype none
module pdmcu_top (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         ascii_mode,
   input  wire logic [15:0]  model_code,
   input  wire logic         rx_valid,
   input  wire logic [7:0]   rx_data,
   output logic              rx_ready,
   output logic              tx_valid,
   output pdmcu_pkg::pdmcu_byte_s tx,
   input  wire logic         tx_ready,
   output logic              mem_valid,
   output pdmcu_pkg::pdmcu_mem_req_s mem_req,
   input  wire logic         mem_done,
   input  wire logic [15:0]  mem_rdata,
   output logic              run_req,
   output logic              stop_req
);
   typedef enum logic [3:0] {
      ST_CMD, ST_HDR, ST_CHECK, ST_DRAIN, ST_STAT, ST_RD_MEM, ST_RD_TX,
      ST_WR_RX, ST_WR_MEM, ST_MODEL, ST_ECHO
   } pdmcu_state_e;

   pdmcu_state_e state, next_state;
   logic [7:0]  cmd, next_cmd, code, next_code, err, next_err;
   logic [15:0] num, next_num, cnt, next_cnt, idx, next_idx;
   logic [15:0] drain, next_drain, wbuf, next_wbuf;
   logic [39:0] sbuf, next_sbuf;
   logic [2:0]  hcnt, next_hcnt, bcnt, next_bcnt;
   logic        half, next_half, go, next_go;
   logic        run_q, next_run, stop_q, next_stop;
   pdmcu_pkg::pdmcu_mem_req_s mreq, next_mreq;
   // serialiser controls
   logic        pk_start, pk_two, pk_last, pk_idle;
   logic [15:0] pk_word;
   // decode helpers
   logic        rx_take, wdev, hi_cnt, bad05;
   logic [2:0]  hdr_len, need;
   logic [15:0] h_num, h_cnt, lim, last_num, step;
   logic [7:0]  h_code, chk;

   pdmcu_word_ser u_ser (
      .clk      (clk),
      .arst_n   (arst_n),
      .start    (pk_start),
      .two      (pk_two),
      .last     (pk_last),
      .word     (pk_word),
      .idle     (pk_idle),
      .tx_valid (tx_valid),
      .tx       (tx),
      .tx_ready (tx_ready)
   );

   ////////////////////////////////////////////////////////////////////
   // header layout and per-command limits
   always_comb begin
      unique case (rx_data)
         pdmcu_pkg::CMD_RD_BIT, pdmcu_pkg::CMD_RD_WORD,
         pdmcu_pkg::CMD_WR_BIT, pdmcu_pkg::CMD_WR_WORD:
            hdr_len = pdmcu_pkg::HDR_BATCH;
         pdmcu_pkg::CMD_TST_BIT, pdmcu_pkg::CMD_TST_WRD,
         pdmcu_pkg::CMD_LOOP:
            hdr_len = pdmcu_pkg::HDR_COUNT;
         default: hdr_len = pdmcu_pkg::HDR_NONE;
      endcase
      // batch headers: code, number L/H, count L/H
      if (hdr_len_batch(cmd)) begin
         h_code = sbuf[7:0];
         h_num  = sbuf[23:8];
         h_cnt  = sbuf[39:24];
      end else begin
         h_code = 8'h00;
         h_num  = 16'h0000;
         h_cnt  = {8'h00, sbuf[39:32]};
      end
      wdev     = h_code[pdmcu_pkg::DEV_WORD_BIT];
      last_num = h_num + h_cnt - 16'h0001;
      hi_cnt   = (h_code == pdmcu_pkg::DEV_CNT_CUR)
                 && (last_num >= pdmcu_pkg::CNT_HI_FIRST);
      unique case (cmd)
         pdmcu_pkg::CMD_RD_BIT:  lim = pdmcu_pkg::LIM_RD_BIT;
         pdmcu_pkg::CMD_RD_WORD: lim = wdev ? pdmcu_pkg::LIM_WORD
                                            : pdmcu_pkg::LIM_RD_BWRD;
         pdmcu_pkg::CMD_WR_BIT:  lim = pdmcu_pkg::LIM_WR_BIT;
         pdmcu_pkg::CMD_WR_WORD: lim = wdev ? pdmcu_pkg::LIM_WORD
                                            : pdmcu_pkg::LIM_WR_BWRD;
         pdmcu_pkg::CMD_TST_BIT: lim = pdmcu_pkg::LIM_TST_BIT;
         pdmcu_pkg::CMD_TST_WRD: lim = pdmcu_pkg::LIM_TST_WRD;
         pdmcu_pkg::CMD_LOOP:    lim = pdmcu_pkg::LIM_LOOP;
         default:                lim = 16'hffff;
      endcase
      // only binary code is served; ascii setting is answered abnormal
      chk = pdmcu_pkg::STS_OK;
      if (ascii_mode)
         chk = pdmcu_pkg::STS_MODE;
      else if (!known(cmd))
         chk = pdmcu_pkg::STS_CMD;
      else if (hdr_len_cnt(cmd) && (h_cnt == 16'h0000 || h_cnt > lim))
         chk = pdmcu_pkg::STS_CNT;
      else if (hdr_len_batch(cmd) && hi_cnt
               && (h_cnt > pdmcu_pkg::LIM_HI_CNT
                   || h_num < pdmcu_pkg::CNT_HI_FIRST))
         chk = pdmcu_pkg::STS_CNT;          // guarded anyway
      else if ((cmd == pdmcu_pkg::CMD_RD_WORD
                || cmd == pdmcu_pkg::CMD_WR_WORD)
               && !wdev && h_num[3:0] != 4'h0)
         chk = pdmcu_pkg::STS_DEV;
      // bytes per write unit
      unique case (cmd)
         pdmcu_pkg::CMD_WR_BIT:  need = 3'd1;
         pdmcu_pkg::CMD_WR_WORD: need = 3'd2;
         pdmcu_pkg::CMD_TST_BIT: need = 3'd4;
         pdmcu_pkg::CMD_TST_WRD: need = 3'd5;
         default:                need = 3'd1;
      endcase
      step  = (code[pdmcu_pkg::DEV_WORD_BIT] || cmd == pdmcu_pkg::CMD_RD_BIT
               || cmd == pdmcu_pkg::CMD_WR_BIT) ? idx : {idx[11:0], 4'h0};
      bad05 = (cmd == pdmcu_pkg::CMD_TST_WRD)
              && (sbuf[7:0] == pdmcu_pkg::DEV_CNT_CUR)
              && (sbuf[23:8] >= pdmcu_pkg::CNT_HI_FIRST);
   end

   function automatic logic hdr_len_batch(input logic [7:0] c);
      return c <= pdmcu_pkg::CMD_WR_WORD;
   endfunction

   function automatic logic hdr_len_cnt(input logic [7:0] c);
      return c <= pdmcu_pkg::CMD_TST_WRD || c == pdmcu_pkg::CMD_LOOP;
   endfunction

   function automatic logic known(input logic [7:0] c);
      return hdr_len_cnt(c) || c == pdmcu_pkg::CMD_RUN
             || c == pdmcu_pkg::CMD_STOP || c == pdmcu_pkg::CMD_MODEL;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // command sequencer
   always_comb begin
      next_state = state;
      next_cmd   = cmd;
      next_code  = code;
      next_err   = err;
      next_num   = num;
      next_cnt   = cnt;
      next_idx   = idx;
      next_drain = drain;
      next_wbuf  = wbuf;
      next_sbuf  = sbuf;
      next_hcnt  = hcnt;
      next_bcnt  = bcnt;
      next_half  = half;
      next_go    = go;
      next_mreq  = mreq;
      next_run   = 1'b0;
      next_stop  = 1'b0;
      pk_start   = 1'b0;
      pk_two     = 1'b0;
      pk_last    = 1'b0;
      pk_word    = 16'h0000;
      rx_ready   = 1'b0;
      rx_take    = 1'b0;
      unique case (state)
         ST_CMD: begin
            rx_ready = 1'b1;
            if (rx_valid) begin
               next_cmd  = rx_data;
               next_hcnt = hdr_len;
               next_idx  = 16'h0000;
               next_half = 1'b0;
               next_bcnt = 3'd0;
               next_sbuf = 40'h0;
               next_state = (hdr_len == 3'd0) ? ST_CHECK : ST_HDR;
            end
         end
         ST_HDR: begin
            rx_ready = 1'b1;
            if (rx_valid) begin
               next_sbuf = {rx_data, sbuf[39:8]};
               next_hcnt = hcnt - 3'd1;
               if (hcnt == 3'd1)
                  next_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            next_code = h_code;
            next_num  = h_num;
            next_cnt  = h_cnt;
            next_err  = chk;
            // a refused frame still has its payload swallowed
            unique case (cmd)
               pdmcu_pkg::CMD_WR_BIT:  next_drain = (h_cnt + 16'h1) >> 1;
               pdmcu_pkg::CMD_WR_WORD: next_drain = h_cnt << 1;
               pdmcu_pkg::CMD_TST_BIT: next_drain = h_cnt << 2;
               pdmcu_pkg::CMD_TST_WRD: next_drain = (h_cnt << 2) + h_cnt;
               pdmcu_pkg::CMD_LOOP:    next_drain = h_cnt;
               default:                next_drain = 16'h0000;
            endcase
            if (chk != pdmcu_pkg::STS_OK || ascii_mode)
               next_state = (next_drain == 16'h0000 || !known(cmd))
                            ? ST_STAT : ST_DRAIN;
            else if (cmd >= pdmcu_pkg::CMD_WR_BIT
                     && cmd <= pdmcu_pkg::CMD_TST_WRD)
               next_state = ST_WR_RX;
            else begin
               next_run   = (cmd == pdmcu_pkg::CMD_RUN);
               next_stop  = (cmd == pdmcu_pkg::CMD_STOP);
               next_state = ST_STAT;
            end
         end
         ST_DRAIN: begin
            rx_ready = 1'b1;
            if (rx_valid) begin
               next_drain = drain - 16'h0001;
               if (drain == 16'h0001)
                  next_state = ST_STAT;
            end
         end
         ST_STAT: if (pk_idle) begin
            pk_start = 1'b1;
            pk_word  = {8'h00, err};
            pk_last  = err != pdmcu_pkg::STS_OK
                       || !(cmd == pdmcu_pkg::CMD_RD_BIT
                            || cmd == pdmcu_pkg::CMD_RD_WORD
                            || cmd == pdmcu_pkg::CMD_MODEL
                            || cmd == pdmcu_pkg::CMD_LOOP);
            if (pk_last)
               next_state = ST_CMD;
            else if (cmd == pdmcu_pkg::CMD_MODEL)
               next_state = ST_MODEL;
            else if (cmd == pdmcu_pkg::CMD_LOOP)
               next_state = ST_ECHO;
            else
               next_state = ST_RD_MEM;
         end
         ST_RD_MEM: begin
            if (!go) begin
               next_go         = 1'b1;
               next_mreq.we    = 1'b0;
               next_mreq.wmode = (cmd == pdmcu_pkg::CMD_RD_WORD);
               next_mreq.code  = code;
               next_mreq.num   = num + step;
               next_mreq.wdata = 16'h0000;
            end else if (mem_done) begin
               next_go  = 1'b0;
               next_idx = idx + 16'h0001;
               if (cmd == pdmcu_pkg::CMD_RD_WORD) begin
                  next_wbuf  = mem_rdata;
                  next_state = ST_RD_TX;
               end else if (!half) begin
                  next_wbuf  = {11'h000, mem_rdata[0], 4'h0};
                  next_half  = 1'b1;
                  if (next_idx == cnt)
                     next_state = ST_RD_TX;
               end else begin
                  next_wbuf[0] = mem_rdata[0];
                  next_state   = ST_RD_TX;
               end
            end
         end
         ST_RD_TX: if (pk_idle) begin
            pk_start   = 1'b1;
            pk_word    = wbuf;
            pk_two     = (cmd == pdmcu_pkg::CMD_RD_WORD);
            pk_last    = (idx == cnt);
            next_half  = 1'b0;
            next_state = pk_last ? ST_CMD : ST_RD_MEM;
         end
         ST_WR_RX: begin
            rx_ready = 1'b1;
            if (rx_valid) begin
               next_sbuf = {rx_data, sbuf[39:8]};
               next_bcnt = bcnt + 3'd1;
               if (next_bcnt == need) begin
                  next_bcnt  = 3'd0;
                  next_state = ST_WR_MEM;
               end
            end
         end
         ST_WR_MEM: begin
            rx_take = go && mem_done || !go && bad05;
            if (!go && !bad05) begin
               next_go         = 1'b1;
               next_mreq.we    = 1'b1;
               next_mreq.code  = code;
               next_mreq.num   = num + step;
               next_mreq.wmode = 1'b0;
               next_mreq.wdata = 16'h0000;
               unique case (cmd)
                  pdmcu_pkg::CMD_WR_BIT:
                     next_mreq.wdata[0] = half ? sbuf[32] : sbuf[36];
                  pdmcu_pkg::CMD_WR_WORD: begin
                     next_mreq.wmode = 1'b1;
                     next_mreq.wdata = sbuf[39:24];
                  end
                  pdmcu_pkg::CMD_TST_BIT: begin
                     next_mreq.code     = sbuf[15:8];
                     next_mreq.num      = sbuf[31:16];
                     next_mreq.wdata[0] = |sbuf[39:32];
                  end
                  default: begin
                     next_mreq.wmode = 1'b1;
                     next_mreq.code  = sbuf[7:0];
                     next_mreq.num   = sbuf[23:8];
                     next_mreq.wdata = sbuf[39:24];
                  end
               endcase
            end
            if (rx_take) begin
               next_go  = 1'b0;
               next_idx = idx + 16'h0001;
               if (bad05)
                  next_err = pdmcu_pkg::STS_DEV;
               next_half = (cmd == pdmcu_pkg::CMD_WR_BIT) && !half
                           && (next_idx != cnt);
               if (next_idx == cnt)
                  next_state = ST_STAT;
               else if (!next_half)
                  next_state = ST_WR_RX;
            end
         end
         ST_MODEL: if (pk_idle) begin
            pk_start   = 1'b1;
            pk_two     = 1'b1;
            pk_last    = 1'b1;
            pk_word    = model_code;
            next_state = ST_CMD;
         end
         ST_ECHO: begin
            // one byte in flight keeps the echo unbuffered
            rx_ready = pk_idle;
            if (rx_valid && pk_idle) begin
               pk_start   = 1'b1;
               pk_word    = {8'h00, rx_data};
               next_idx   = idx + 16'h0001;
               pk_last    = (next_idx == cnt);
               if (pk_last)
                  next_state = ST_CMD;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state  <= ST_CMD;
         cmd    <= 8'h00;
         code   <= 8'h00;
         err    <= 8'h00;
         num    <= 16'h0000;
         cnt    <= 16'h0000;
         idx    <= 16'h0000;
         drain  <= 16'h0000;
         wbuf   <= 16'h0000;
         sbuf   <= 40'h0;
         hcnt   <= 3'd0;
         bcnt   <= 3'd0;
         half   <= 1'b0;
         go     <= 1'b0;
         mreq   <= '0;
         run_q  <= 1'b0;
         stop_q <= 1'b0;
      end else begin
         state  <= next_state;
         cmd    <= next_cmd;
         code   <= next_code;
         err    <= next_err;
         num    <= next_num;
         cnt    <= next_cnt;
         idx    <= next_idx;
         drain  <= next_drain;
         wbuf   <= next_wbuf;
         sbuf   <= next_sbuf;
         hcnt   <= next_hcnt;
         bcnt   <= next_bcnt;
         half   <= next_half;
         go     <= next_go;
         mreq   <= next_mreq;
         run_q  <= next_run;
         stop_q <= next_stop;
      end
   end

   // memory request stands from its register until mem_done
   assign mem_valid = go;
   assign mem_req   = mreq;
   assign run_req   = run_q;
   assign stop_req  = stop_q;
endmodule
`default_nettype wire

/* src/pdmcu_word_ser.sv */
// serialiser sending one byte or a 16-bit word low byte first
`default_nettype none
module pdmcu_word_ser (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         start,
   input  wire logic         two,
   input  wire logic         last,
   input  wire logic [15:0]  word,
   output logic              idle,
   output logic              tx_valid,
   output pdmcu_pkg::pdmcu_byte_s tx,
   input  wire logic         tx_ready
);
   logic       valid, next_valid;
   logic       pend, next_pend;
   logic       lastw, next_lastw;
   logic [7:0] hi, next_hi;
   pdmcu_pkg::pdmcu_byte_s cur, next_cur;

   ////////////////////////////////////////////////////////////////////
   // next byte; high half waits behind low half
   always_comb begin
      next_valid = valid;
      next_pend  = pend;
      next_lastw = lastw;
      next_hi    = hi;
      next_cur   = cur;
      if (start && !valid) begin
         next_valid    = 1'b1;
         next_pend     = two;
         next_lastw    = last;
         next_hi       = word[15:8];
         next_cur.data = word[7:0];
         next_cur.last = last && !two;
      end else if (valid && tx_ready) begin
         if (pend) begin
            next_pend     = 1'b0;
            next_cur.data = hi;
            next_cur.last = lastw;
         end else begin
            next_valid = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         valid <= 1'b0;
         pend  <= 1'b0;
         lastw <= 1'b0;
         hi    <= 8'h00;
         cur   <= '0;
      end else begin
         valid <= next_valid;
         pend  <= next_pend;
         lastw <= next_lastw;
         hi    <= next_hi;
         cur   <= next_cur;
      end
   end

   assign idle     = !valid;
   assign tx_valid = valid;
   assign tx       = cur;
endmodule
`default_nettype wire

/* testbench/pdmcu_mem_model.sv */
// controller device memory model answering the command unit
`default_nettype none
module pdmcu_mem_model (
   input wire logic                      clk,
   input wire logic                      arst_n,
   input wire logic [3:0]                lat,
   input wire logic                      mem_valid,
   input wire pdmcu_pkg::pdmcu_mem_req_s mem_req,
   output logic                          mem_done,
   output logic [15:0]                   mem_rdata,
   output logic [31:0]                   last_w
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_cnt;
   // answers lat+1 cycles after the request; data line is junk between answers
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_cnt <= 4'h0;
         mem_done <= 1'b0;
         mem_rdata <= 16'h0000;
         last_w <= 32'h0;
      end else begin
         mem_done <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_valid && !mem_done) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt >= lat) begin
               wait_cnt <= 4'h0;
               mem_done <= 1'b1;
               // stored pattern returned raw, never converted
               mem_rdata <= mem_req.wmode ?
                  {mem_req.num[7:0] ^ 8'ha5, mem_req.num[7:0]} :
                  {15'h0, mem_req.num[0]};
               if (mem_req.we) last_w <= {mem_req.num, mem_req.wdata};
            end
         end
      end
   end
endmodule
`default_nettype wire

/* testbench/pdmcu_sva.sv */
// port checker of the device memory command unit
`default_nettype none
module pdmcu_sva (
   input wire logic                      clk,
   input wire logic                      arst_n,
   input wire logic                      ascii_mode,
   input wire logic                      rx_ready,
   input wire logic                      tx_valid,
   input wire pdmcu_pkg::pdmcu_byte_s    tx,
   input wire logic                      tx_ready,
   input wire logic                      mem_valid,
   input wire pdmcu_pkg::pdmcu_mem_req_s mem_req,
   input wire logic                      mem_done,
   input wire logic                      run_req,
   input wire logic                      stop_req
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////
   // stream and memory requests hold until taken
   property p_txh; tx_valid && !tx_ready |=> tx_valid && $stable(tx);
   endproperty
   a_txh: assert property (p_txh) else $error("tx moved");
   property p_memh; mem_valid && !mem_done |=> mem_valid && $stable(mem_req);
   endproperty
   a_memh: assert property (p_memh) else $error("mem moved");
   // run and stop are single pulses answered by a lone ok status
   property p_pulse; run_req || stop_req |=> !run_req && !stop_req;
   endproperty
   a_pulse: assert property (p_pulse) else $error("long pulse");
   property p_runok;
      run_req |=> tx_valid && tx.data == pdmcu_pkg::STS_OK && tx.last;
   endproperty
   a_runok: assert property (p_runok) else $error("run answer");
   property p_stopok;
      stop_req |=> tx_valid && tx.data == pdmcu_pkg::STS_OK && tx.last;
   endproperty
   a_stopok: assert property (p_stopok) else $error("stop answer");
   // ascii setting is refused outright, nothing reaches the controller
   property p_asc;
      tx_valid && ascii_mode |-> tx.data == pdmcu_pkg::STS_MODE && tx.last;
   endproperty
   a_asc: assert property (p_asc) else $error("ascii answer");
   property p_ascm; ascii_mode |-> !mem_valid && !run_req && !stop_req;
   endproperty
   a_ascm: assert property (p_ascm) else $error("ascii acted");
   // input is open only while nothing is driven at the controller;
   // idle may take a byte while the last answer byte still waits
   property p_rxtx; rx_ready |-> !mem_valid && !run_req && !stop_req;
   endproperty
   a_rxtx: assert property (p_rxtx) else $error("rx open");
   c_run: cover property (run_req);
   c_mode: cover property (tx_valid && tx.data == pdmcu_pkg::STS_MODE);
   c_wr: cover property (mem_done && mem_req.we);
endmodule
bind pdmcu_top pdmcu_sva i_sva (.clk, .arst_n, .ascii_mode, .rx_ready,
   .tx_valid, .tx, .tx_ready, .mem_valid, .mem_req, .mem_done, .run_req,
   .stop_req);
`default_nettype wire

/* testbench/tb_plc_device_memory_command_unit.sv */
// self-checking bench of the device memory command unit
`default_nettype none
module tb_plc_device_memory_command_unit;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      int ni; logic [63:0] i; int no; logic [39:0] o; logic [33:0] w;
   } pdmcu_row_s;
   logic clk, arst_n, ascii_mode, rx_valid, rx_ready, tx_valid, tx_ready;
   logic mem_valid, mem_done, run_req, stop_req;
   logic [7:0]  rx_data;
   logic [15:0] mem_rdata;
   logic [31:0] last_w;
   logic [3:0]  lat;
   pdmcu_pkg::pdmcu_byte_s    tx;
   pdmcu_pkg::pdmcu_mem_req_s mem_req;
   int failures = 0;
   int checks_done = 0;
   // frame bytes, answer bytes, last write {full, check, num, data}
   pdmcu_row_s rows [18] = '{
      '{1, 64'h13, 1, 40'h00, 34'h0},
      '{1, 64'h14, 1, 40'h00, 34'h0},
      '{1, 64'h15, 3, 40'h003412, 34'h0},
      '{8, 64'h030010000100cdab, 1, 40'h00, 34'h3_0010_abcd},
      '{6, 64'h00000b000300, 3, 40'h001010, 34'h0},
      '{6, 64'h018005000200, 5, 40'h0005a006a3, 34'h0},
      '{6, 64'h010010000100, 3, 40'h0010b5, 34'h0},
      '{7, 64'h02000400020001, 1, 40'h00, 34'h1_0005_0001},
      '{8, 64'h0380070001003412, 1, 40'h00, 34'h3_0007_1234},
      '{6, 64'h040100090001, 1, 40'h00, 34'h1_0009_0001},
      '{7, 64'h0501800200cdab, 1, 40'h00, 34'h3_0002_abcd},
      '{7, 64'h050183c8001122, 1, 40'h53, 34'h0},
      '{1, 64'h77, 1, 40'h50, 34'h0},
      '{6, 64'h000000000101, 1, 40'h51, 34'h0},
      '{6, 64'h0183c8002100, 1, 40'h51, 34'h0},
      '{6, 64'h010008000100, 1, 40'h53, 34'h0},
      '{2, 64'h1600, 1, 40'h51, 34'h0},
      '{6, 64'h0183c7000200, 1, 40'h51, 34'h0}};
   pdmcu_top i_dut (.clk, .arst_n, .ascii_mode, .model_code(16'h1234),
      .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx, .tx_ready, .mem_valid,
      .mem_req, .mem_done, .mem_rdata, .run_req, .stop_req);
   pdmcu_mem_model i_mem (.clk, .arst_n, .lat, .mem_valid, .mem_req,
      .mem_done, .mem_rdata, .last_w);
   ////////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   always #20 clk = ~clk;
   task finish_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input bit ok);
      checks_done++;
      if (!ok) begin
         failures++;
         $display("ERROR %0t mismatch", $time);
      end
   endtask
   // bounded wait, sampled on the falling edge where lines are settled
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      @(negedge clk);
      while (s !== 1'b1) begin
         n++;
         if (n > 500) begin
            failures++;
            finish_test();
         end
         @(negedge clk);
      end
   endtask
   task send(input logic [7:0] b);
      rx_valid <= 1'b1;
      rx_data <= b;
      wait_hi(rx_ready);
      @(posedge clk);
   endtask
   // far side stalls each answer byte one cycle to exercise the hold
   task recv(input logic [7:0] e, input logic l);
      wait_hi(tx_valid);
      chk(tx.data === e && tx.last === l);
      @(posedge clk);
      tx_ready <= 1'b1;
      @(posedge clk);
      tx_ready <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0; arst_n = 1'b0; ascii_mode = 1'b0; rx_valid = 1'b0;
      rx_data = 8'h00; tx_ready = 1'b0; lat = 4'h0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      chk(rx_ready === 1'b1 && tx_valid === 1'b0 && mem_valid === 1'b0);
      for (int k = 0; k < 18; k++) begin
         @(posedge clk);
         lat <= k[0] ? 4'h3 : 4'h0;
         for (int j = 0; j < rows[k].ni; j++)
            send(rows[k].i[8*(rows[k].ni-1-j) +: 8]);
         rx_valid <= 1'b0;
         for (int j = 0; j < rows[k].no; j++)
            recv(rows[k].o[8*(rows[k].no-1-j) +: 8], j == rows[k].no-1);
         if (rows[k].w[32])
            chk(last_w[31:16] === rows[k].w[31:16] && last_w[0] ===
               rows[k].w[0] && (!rows[k].w[33] ||
               last_w[15:1] === rows[k].w[15:1]));
         $display("row %0d done", k);
      end
      // loopback: each byte is echoed before the next one is taken
      send(8'h16);
      send(8'h02);
      rx_valid <= 1'b0;
      recv(8'h00, 1'b0);
      send(8'haa);
      rx_valid <= 1'b0;
      recv(8'haa, 1'b0);
      send(8'h55);
      rx_valid <= 1'b0;
      recv(8'h55, 1'b1);
      $display("echo test done");
      // ascii setting refused
      ascii_mode <= 1'b1;
      send(8'h13);
      rx_valid <= 1'b0;
      recv(8'h52, 1'b1);
      ascii_mode <= 1'b0;
      $display("ascii test done");
      // reset in mid-frame drops the partial command
      send(8'h01);
      rx_valid <= 1'b0;
      arst_n <= 1'b0;
      @(negedge clk);
      chk(rx_ready === 1'b1 && tx_valid === 1'b0 && mem_valid === 1'b0);
      @(posedge clk);
      arst_n <= 1'b1;
      send(8'h14);
      rx_valid <= 1'b0;
      recv(8'h00, 1'b1);
      $display("reset test done");
      finish_test();
   end
endmodule
`default_nettype wire
